// ---- e1tx_pkg.sv ----
// constants and types for the e1 transmit clock and mode detector
// Notes on behaviour
// RULE1: negative rail high over 16 transmit clocks selects single rail mode 1.
// RULE2: far end supplies a 2.048 MHz transmit clock for normal operation.
// RULE3: transmit data is captured on falling transmit clock edges; far end keeps it stable.
// RULE4: transmit clock high over 16 reference cycles selects the all-ones state.
// RULE5: in the all-ones state the pattern is paced by the master clock.
// RULE6: in the all-ones state a continuous all-ones signal goes to the line.
// RULE7: transmit clock held low powers the channel down with drivers high impedance.
// RULE8: any transition clears stuck counters; clock toggling again restores normal operation.
`default_nettype none

package e1tx_pkg;

    // master clock of this block
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // 2.048 MHz reference period, one line bit
    localparam int unsigned REF_PERIOD_PS = 488281;
    localparam int unsigned STUCK_REF_CYCLES = 16;
    localparam int unsigned STUCK_TIME_PS = STUCK_REF_CYCLES * REF_PERIOD_PS;
    // more than the stuck time: round up to whole master cycles
    localparam int unsigned STUCK_CYCLES = (STUCK_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // all-ones bit pacing, rounded down
    localparam int unsigned AOS_BIT_CYCLES = REF_PERIOD_PS / CLK_PERIOD_PS;
    localparam int unsigned NEG_RAIL_LIMIT = 16;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned SYNC_STAGES = 2;

    typedef struct packed {
        logic pos;
        logic neg;
    } e1tx_sym_t;

    typedef enum logic [1:0] {
        E1TX_NORMAL,
        E1TX_ALL_ONES,
        E1TX_POWER_DOWN
    } e1tx_mode_t;

endpackage : e1tx_pkg

`default_nettype wire

// ---- e1tx_sync.sv ----
// two-flop level synchroniser, one per bit
`default_nettype none

module e1tx_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    if (WIDTH < 1) begin : g_bad_width
        $error("e1tx_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule : e1tx_sync

`default_nettype wire

// ---- e1tx_fifo.sv ----
// dual-clock fifo with gray-coded pointers
`default_nettype none

module e1tx_fifo #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 32
) (
    input wire logic rst,
    input wire logic wr_clk,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_clk,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);

    localparam int unsigned AW = $clog2(DEPTH);

    // the full test slices two top pointer bits, so four entries at the least
    if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("e1tx_fifo: DEPTH must be a power of two of at least 4");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_bin_r, wr_bin_nxt, wr_gray_r, wr_gray_nxt;
    logic [AW:0] rd_bin_r, rd_bin_nxt, rd_gray_r, rd_gray_nxt;
    logic [AW:0] rd_gray_w, wr_gray_rd;
    logic full_r, full_nxt, empty_r, empty_nxt;
    logic do_wr, do_rd;

    assign do_wr = wr_valid && !full_r;
    assign do_rd = rd_ready && !empty_r;

    e1tx_sync #(.WIDTH(AW + 1)) u_rd_to_wr (
        .clk(wr_clk),
        .rst(rst),
        .d(rd_gray_r),
        .q(rd_gray_w)
    );

    e1tx_sync #(.WIDTH(AW + 1)) u_wr_to_rd (
        .clk(rd_clk),
        .rst(rst),
        .d(wr_gray_r),
        .q(wr_gray_rd)
    );

    always_comb begin
        wr_bin_nxt = wr_bin_r + (AW + 1)'(do_wr);
        wr_gray_nxt = wr_bin_nxt ^ (wr_bin_nxt >> 1);
        full_nxt = wr_gray_nxt == {~rd_gray_w[AW:AW-1], rd_gray_w[AW-2:0]};
    end

    always_ff @(posedge wr_clk or posedge rst) begin
        if (rst) begin
            wr_bin_r <= '0;
            wr_gray_r <= '0;
            full_r <= 1'b0;
        end else begin
            wr_bin_r <= wr_bin_nxt;
            wr_gray_r <= wr_gray_nxt;
            full_r <= full_nxt;
        end
    end

    // storage has no reset so it maps to plain memory
    always_ff @(posedge wr_clk) begin
        if (do_wr) begin
            mem[wr_bin_r[AW-1:0]] <= wr_data;
        end
    end

    always_comb begin
        rd_bin_nxt = rd_bin_r + (AW + 1)'(do_rd);
        rd_gray_nxt = rd_bin_nxt ^ (rd_bin_nxt >> 1);
        empty_nxt = rd_gray_nxt == wr_gray_rd;
    end

    always_ff @(posedge rd_clk or posedge rst) begin
        if (rst) begin
            rd_bin_r <= '0;
            rd_gray_r <= '0;
            empty_r <= 1'b1;
        end else begin
            rd_bin_r <= rd_bin_nxt;
            rd_gray_r <= rd_gray_nxt;
            empty_r <= empty_nxt;
        end
    end

    assign wr_ready = !full_r;
    assign rd_valid = !empty_r;
    assign rd_data = mem[rd_bin_r[AW-1:0]];

endmodule : e1tx_fifo

`default_nettype wire

// ---- e1tx_clock_mode_detect.sv ----
// per-channel transmit clock capture and transmit mode detection
`default_nettype none

module e1tx_clock_mode_detect #(
    parameter int unsigned STUCK_LIMIT = e1tx_pkg::STUCK_CYCLES,
    parameter int unsigned FIFO_DEPTH = e1tx_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_clock_in,
    input wire logic tx_data_pos_in,
    input wire logic tx_neg_rail_in,
    input wire logic line_ready,
    output e1tx_pkg::e1tx_sym_t line_sym_r,
    output logic line_valid_r,
    output logic line_oe_r,
    output e1tx_pkg::e1tx_mode_t mode_r,
    output logic all_ones_transmit_state_r,
    output logic single_rail_mode_r,
    output logic tx_accept_r
);

    localparam int unsigned SCW = $clog2(STUCK_LIMIT + 2);
    localparam int unsigned NCW = $clog2(e1tx_pkg::NEG_RAIL_LIMIT + 2);
    localparam int unsigned DCW = $clog2(e1tx_pkg::AOS_BIT_CYCLES + 1);
    localparam logic [SCW-1:0] STUCK_TRIP = SCW'(STUCK_LIMIT + 1);
    localparam logic [NCW-1:0] NEG_TRIP = NCW'(e1tx_pkg::NEG_RAIL_LIMIT + 1);
    localparam logic [DCW-1:0] AOS_LAST = DCW'(e1tx_pkg::AOS_BIT_CYCLES - 1);

    if (STUCK_LIMIT < 2) begin : g_bad_stuck
        $error("e1tx_clock_mode_detect: STUCK_LIMIT must be at least 2");
    end
    if (FIFO_DEPTH < 4) begin : g_bad_depth
        $error("e1tx_clock_mode_detect: FIFO_DEPTH must be at least 4");
    end
    // the all-ones divider needs room between two marks
    if (e1tx_pkg::AOS_BIT_CYCLES < 2) begin : g_bad_pace
        $error("e1tx_clock_mode_detect: all-ones bit pacing too short");
    end

    // ---------------- link domain, falling edge of the transmit clock

    logic tx_clk_n;
    assign tx_clk_n = ~tx_clock_in;

    // reset for the link side: asserts at once, releases on a link edge
    logic link_rst_meta_r, link_rst_meta_nxt;
    logic link_rst_r, link_rst_nxt;

    always_comb begin
        link_rst_meta_nxt = 1'b0;
        link_rst_nxt = link_rst_meta_r;
    end

    always_ff @(posedge tx_clk_n or posedge rst) begin
        if (rst) begin
            link_rst_meta_r <= 1'b1;
            link_rst_r <= 1'b1;
        end else begin
            link_rst_meta_r <= link_rst_meta_nxt;
            link_rst_r <= link_rst_nxt;
        end
    end

    // consecutive high samples of the negative rail
    logic [NCW-1:0] neg_cnt_r, neg_cnt_nxt;
    logic single_rail_link_r, single_rail_link_nxt;
    logic tx_accept_nxt;
    logic fifo_wr_ready;
    logic fifo_wr_valid;
    e1tx_pkg::e1tx_sym_t fifo_wr_data;

    always_comb begin
        neg_cnt_nxt = neg_cnt_r;
        single_rail_link_nxt = single_rail_link_r;
        if (!tx_neg_rail_in) begin
            neg_cnt_nxt = '0; // RULE8
        end else if (neg_cnt_r != NEG_TRIP) begin
            neg_cnt_nxt = neg_cnt_r + NCW'(1);
        end
        if (neg_cnt_nxt == NEG_TRIP) begin
            single_rail_link_nxt = 1'b1; // RULE1
        end else if (!tx_neg_rail_in && neg_cnt_r != NEG_TRIP) begin
            single_rail_link_nxt = single_rail_link_r;
        end
        tx_accept_nxt = fifo_wr_ready;
    end

    always_ff @(posedge tx_clk_n or posedge rst) begin
        if (rst) begin
            neg_cnt_r <= '0;
            single_rail_link_r <= 1'b0;
            tx_accept_r <= 1'b0;
        end else if (link_rst_r) begin
            neg_cnt_r <= '0;
            single_rail_link_r <= 1'b0;
            tx_accept_r <= 1'b0;
        end else begin
            neg_cnt_r <= neg_cnt_nxt;
            single_rail_link_r <= single_rail_link_nxt;
            tx_accept_r <= tx_accept_nxt;
        end
    end

    // pins go into storage on each falling edge while the fifo is not full, negative rail forced low once single rail is set
    always_comb begin
        fifo_wr_valid = !link_rst_r; // RULE3
        fifo_wr_data.pos = tx_data_pos_in;
        fifo_wr_data.neg = tx_neg_rail_in && !single_rail_link_r;
    end

    // ---------------- crossing into the master clock domain

    logic fifo_rd_valid;
    logic fifo_rd_ready;
    e1tx_pkg::e1tx_sym_t fifo_rd_data;

    e1tx_fifo #(
        .WIDTH($bits(e1tx_pkg::e1tx_sym_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .rst(rst),
        .wr_clk(tx_clk_n),
        .wr_valid(fifo_wr_valid),
        .wr_ready(fifo_wr_ready),
        .wr_data(fifo_wr_data),
        .rd_clk(clk),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_rd_ready),
        .rd_data(fifo_rd_data)
    );

    logic [1:0] lvl_sync;
    logic clk_lvl;
    logic single_rail_s;

    e1tx_sync #(.WIDTH(2)) u_lvl_sync (
        .clk(clk),
        .rst(rst),
        .d({single_rail_link_r, tx_clock_in}),
        .q(lvl_sync)
    );

    assign clk_lvl = lvl_sync[0];
    assign single_rail_s = lvl_sync[1];

    // ---------------- master domain: activity watch and mode choice

    // reset for the master side: asserts at once, releases on a clk edge
    logic clk_rst_meta_r, clk_rst_meta_nxt;
    logic clk_rst_r, clk_rst_nxt;

    always_comb begin
        clk_rst_meta_nxt = 1'b0;
        clk_rst_nxt = clk_rst_meta_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_rst_meta_r <= 1'b1;
            clk_rst_r <= 1'b1;
        end else begin
            clk_rst_meta_r <= clk_rst_meta_nxt;
            clk_rst_r <= clk_rst_nxt;
        end
    end

    logic clk_prev_r, clk_prev_nxt;
    logic [SCW-1:0] hi_cnt_r, hi_cnt_nxt;
    logic [SCW-1:0] lo_cnt_r, lo_cnt_nxt;
    e1tx_pkg::e1tx_mode_t mode_nxt;
    logic clk_edge;

    always_comb begin
        clk_edge = clk_lvl != clk_prev_r;
        clk_prev_nxt = clk_lvl;
        hi_cnt_nxt = hi_cnt_r;
        lo_cnt_nxt = lo_cnt_r;
        if (clk_edge || !clk_lvl) begin
            hi_cnt_nxt = '0; // RULE8
        end else if (hi_cnt_r != STUCK_TRIP) begin
            hi_cnt_nxt = hi_cnt_r + SCW'(1);
        end
        if (clk_edge || clk_lvl) begin
            lo_cnt_nxt = '0; // RULE8
        end else if (lo_cnt_r != STUCK_TRIP) begin
            lo_cnt_nxt = lo_cnt_r + SCW'(1);
        end
        mode_nxt = mode_r;
        case (mode_r)
            e1tx_pkg::E1TX_NORMAL: begin
                if (hi_cnt_r == STUCK_TRIP) begin
                    mode_nxt = e1tx_pkg::E1TX_ALL_ONES; // RULE4
                end else if (lo_cnt_r == STUCK_TRIP) begin
                    mode_nxt = e1tx_pkg::E1TX_POWER_DOWN; // RULE7
                end
            end
            e1tx_pkg::E1TX_ALL_ONES: begin
                if (clk_edge) begin
                    mode_nxt = e1tx_pkg::E1TX_NORMAL; // RULE8
                end
            end
            e1tx_pkg::E1TX_POWER_DOWN: begin
                if (clk_edge) begin
                    mode_nxt = e1tx_pkg::E1TX_NORMAL; // RULE8
                end
            end
            default: begin
                mode_nxt = e1tx_pkg::E1TX_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or posedge clk_rst_r) begin
        if (clk_rst_r) begin
            clk_prev_r <= 1'b0;
            hi_cnt_r <= '0;
            lo_cnt_r <= '0;
            mode_r <= e1tx_pkg::E1TX_NORMAL;
        end else begin
            clk_prev_r <= clk_prev_nxt;
            hi_cnt_r <= hi_cnt_nxt;
            lo_cnt_r <= lo_cnt_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ---------------- master domain: line side symbols

    logic [DCW-1:0] aos_div_r, aos_div_nxt;
    logic aos_phase_r, aos_phase_nxt;
    e1tx_pkg::e1tx_sym_t line_sym_nxt;
    logic line_valid_nxt;
    logic line_oe_nxt;
    logic all_ones_nxt;
    logic single_rail_nxt;

    // outside normal mode the buffered link data is stale and is drained
    assign fifo_rd_ready = (mode_r != e1tx_pkg::E1TX_NORMAL) || line_ready;

    always_comb begin
        aos_div_nxt = '0;
        aos_phase_nxt = aos_phase_r;
        line_sym_nxt = '0;
        line_valid_nxt = 1'b0;
        line_oe_nxt = mode_nxt != e1tx_pkg::E1TX_POWER_DOWN; // RULE7
        all_ones_nxt = mode_nxt == e1tx_pkg::E1TX_ALL_ONES;
        single_rail_nxt = single_rail_s; // RULE1
        case (mode_r)
            e1tx_pkg::E1TX_NORMAL: begin
                if (fifo_rd_valid && line_ready) begin
                    line_sym_nxt = fifo_rd_data;
                    line_valid_nxt = 1'b1;
                end
            end
            e1tx_pkg::E1TX_ALL_ONES: begin
                // bit pacing from the master clock, not the link clock
                if (aos_div_r != AOS_LAST) begin
                    aos_div_nxt = aos_div_r + DCW'(1); // RULE5
                end else if (!line_ready) begin
                    aos_div_nxt = aos_div_r;
                end else begin
                    // every bit is a mark, alternating polarity
                    line_sym_nxt.pos = !aos_phase_r; // RULE6
                    line_sym_nxt.neg = aos_phase_r; // RULE6
                    line_valid_nxt = 1'b1;
                    aos_phase_nxt = !aos_phase_r;
                end
            end
            e1tx_pkg::E1TX_POWER_DOWN: begin
                aos_phase_nxt = 1'b0;
            end
            default: begin
                aos_phase_nxt = 1'b0;
            end
        endcase
        // no symbol leaves in the cycle the mode changes, so none meets the wrong driver state
        if (mode_nxt != mode_r) begin
            line_valid_nxt = 1'b0;
            line_sym_nxt = '0;
        end
    end

    always_ff @(posedge clk or posedge clk_rst_r) begin
        if (clk_rst_r) begin
            aos_div_r <= '0;
            aos_phase_r <= 1'b0;
            line_sym_r <= '0;
            line_valid_r <= 1'b0;
            line_oe_r <= 1'b0;
            all_ones_transmit_state_r <= 1'b0;
            single_rail_mode_r <= 1'b0;
        end else begin
            aos_div_r <= aos_div_nxt;
            aos_phase_r <= aos_phase_nxt;
            line_sym_r <= line_sym_nxt;
            line_valid_r <= line_valid_nxt;
            line_oe_r <= line_oe_nxt;
            all_ones_transmit_state_r <= all_ones_nxt;
            single_rail_mode_r <= single_rail_nxt;
        end
    end

endmodule : e1tx_clock_mode_detect

`default_nettype wire

// ---- e1tx_chk.sv ----
// port assertions for the transmit clock and mode detector
`default_nettype none

module e1tx_chk #(
    parameter int unsigned STUCK_LIMIT = e1tx_pkg::STUCK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_clock_in,
    input wire logic tx_data_pos_in,
    input wire logic tx_neg_rail_in,
    input wire logic line_ready,
    input var e1tx_pkg::e1tx_sym_t line_sym_r,
    input wire logic line_valid_r,
    input wire logic line_oe_r,
    input var e1tx_pkg::e1tx_mode_t mode_r,
    input wire logic all_ones_transmit_state_r,
    input wire logic single_rail_mode_r,
    input wire logic tx_accept_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_r;
    logic [15:0] stb_r;
    logic [3:0] run_r;
    logic [7:0] sr_age_r;
    logic aos;
    logic pd;

    assign aos = (mode_r == e1tx_pkg::E1TX_ALL_ONES);
    assign pd = (mode_r == e1tx_pkg::E1TX_POWER_DOWN);

    // cycles the clock pin has held its level, and cycles it has kept toggling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
            stb_r <= 16'h0;
            run_r <= 4'h0;
            sr_age_r <= 8'h0;
        end else begin
            prev_r <= tx_clock_in;
            stb_r <= (tx_clock_in != prev_r) ? 16'h0 : ((&stb_r) ? stb_r : stb_r + 16'h1);
            run_r <= (stb_r > 16'h3) ? 4'h0 : ((&run_r) ? run_r : run_r + 4'h1);
            sr_age_r <= !single_rail_mode_r ? 8'h0 : ((&sr_age_r) ? sr_age_r : sr_age_r + 8'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_high_stuck: assert property (stb_r == 16'(STUCK_LIMIT + 8) && tx_clock_in |-> aos)
        else $error("clock held high did not give all ones");
    a_low_stuck: assert property (stb_r == 16'(STUCK_LIMIT + 8) && !tx_clock_in |-> pd)
        else $error("clock held low did not power down");
    a_toggle_normal: assert property (run_r == 4'h8 |-> !aos && !pd && line_oe_r)
        else $error("toggling clock did not restore normal mode");
    a_aos_flag: assert property (all_ones_transmit_state_r == aos)
        else $error("all ones flag disagrees with mode");
    a_aos_symbol: assert property (aos && line_valid_r |-> (^line_sym_r) && line_oe_r)
        else $error("all ones symbol is not a single mark");
    a_aos_pace: assert property (aos && line_valid_r |=> (!line_valid_r || !aos) [*8])
        else $error("all ones symbols too close together");
    a_pd_quiet: assert property (pd |-> !line_oe_r && !line_valid_r)
        else $error("powered down channel still drives");
    a_sr_sticky: assert property ($rose(single_rail_mode_r) |=> single_rail_mode_r [*8])
        else $error("single rail flag dropped");
    a_sr_neg: assert property (sr_age_r == 8'hFF && line_valid_r && !aos |-> !line_sym_r.neg)
        else $error("negative rail passed in single rail mode");

    c_aos: cover property (aos && line_valid_r);
    c_pd: cover property (pd);
    c_sr: cover property ($rose(single_rail_mode_r));
    c_full: cover property (!tx_accept_r && line_oe_r);
endmodule : e1tx_chk

bind e1tx_clock_mode_detect e1tx_chk #(.STUCK_LIMIT(STUCK_LIMIT)) u_chk (.clk(clk), .rst(rst),
    .tx_clock_in(tx_clock_in), .tx_data_pos_in(tx_data_pos_in),
    .tx_neg_rail_in(tx_neg_rail_in), .line_ready(line_ready), .line_sym_r(line_sym_r),
    .line_valid_r(line_valid_r), .line_oe_r(line_oe_r), .mode_r(mode_r),
    .all_ones_transmit_state_r(all_ones_transmit_state_r),
    .single_rail_mode_r(single_rail_mode_r), .tx_accept_r(tx_accept_r));

`default_nettype wire

// ---- e1tx_framer_model.sv ----
// framer model: transmit clock and data toward the detector
`default_nettype none

module e1tx_framer_model (
    input wire logic run,
    input wire logic hold_lvl,
    input wire logic neg_hi,
    output logic tclk,
    output logic pos,
    output logic neg
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tclk = 1'b0;
        pos = 1'b0;
        neg = 1'b0;
    end

    always begin
        #7.5;
        if (run) begin
            tclk = ~tclk;
        end else if (tclk != hold_lvl) begin
            tclk = hold_lvl;
        end else begin
            // data keeps moving while the clock stands still, but never on its last edge
            pos = ~pos;
            neg = ~neg;
        end
        // new data after the rising edge keeps it stable around the falling one
        if (run && tclk) begin
            pos = 1'($urandom_range(1));
            neg = neg_hi | 1'($urandom_range(1));
        end
    end
endmodule : e1tx_framer_model

`default_nettype wire

// ---- test_e1tx_clock_mode_detect.sv ----
// testbench for the transmit clock and mode detector
`default_nettype none

module test_e1tx_clock_mode_detect;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SL = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b1;
    logic hold_lvl = 1'b0;
    logic neg_hi = 1'b0;
    logic line_ready;
    logic [1:0] rdy_mode = 2'h1;
    logic cmp_on = 1'b1;
    logic tclk;
    logic pos;
    logic neg;
    e1tx_pkg::e1tx_sym_t line_sym_r;
    e1tx_pkg::e1tx_mode_t mode_r;
    logic line_valid_r, line_oe_r, aos_r, sr_r, acc_r;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    int nrun = 0;
    int sr_cnt = 0;
    logic sr_m = 1'b0;
    logic [1:0] q[$];
    logic [1:0] ex;
    logic [1:0] smp;
    logic [1:0] last_aos = 2'h0;

    always #2 clk = ~clk;
    always @(negedge clk) line_ready <= (rdy_mode == 2'h2) ? 1'($urandom_range(1)) : rdy_mode[0];

    e1tx_framer_model u_fr (.run(run), .hold_lvl(hold_lvl), .neg_hi(neg_hi), .tclk(tclk),
        .pos(pos), .neg(neg));
    e1tx_clock_mode_detect #(.STUCK_LIMIT(SL)) DUT (.clk(clk), .rst(rst), .tx_clock_in(tclk),
        .tx_data_pos_in(pos), .tx_neg_rail_in(neg), .line_ready(line_ready),
        .line_sym_r(line_sym_r), .line_valid_r(line_valid_r), .line_oe_r(line_oe_r),
        .mode_r(mode_r), .all_ones_transmit_state_r(aos_r), .single_rail_mode_r(sr_r),
        .tx_accept_r(acc_r));

    task automatic cmp(input string nm, input logic [3:0] e, input logic [3:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask : cmp

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w

    // reference model of the sampled stream and the negative rail watch
    // the accept flag tells, after the edge, whether that edge's sample was stored
    always @(negedge tclk) begin
        smp = {pos, neg & ~sr_m};
        sr_cnt = (neg === 1'b1 && !rst) ? sr_cnt + 1 : 0;
        if (sr_cnt > 16) begin
            sr_m = 1'b1;
        end
        #1;
        if (acc_r === 1'b1 && !rst) begin
            q.push_back(smp);
        end
    end

    always @(negedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // outputs are looked at mid-cycle, where they have settled
    always @(negedge clk) begin
        if (line_valid_r === 1'b1 && mode_r === e1tx_pkg::E1TX_NORMAL && cmp_on) begin
            ex = (q.size() > 0) ? q.pop_front() : 2'hX;
            cmp("line_sym", {2'h0, ex}, {2'h0, line_sym_r});
        end
        if (line_valid_r === 1'b1 && mode_r === e1tx_pkg::E1TX_ALL_ONES) begin
            cmp("aos_mark", 4'h1, {3'h0, ^line_sym_r});
            if (last_aos != 2'h0) begin
                cmp("aos_alt", {2'h0, ~last_aos}, {2'h0, line_sym_r});
            end
            last_aos = line_sym_r;
            nrun++;
        end
    end

    task automatic chk_mode(input e1tx_pkg::e1tx_mode_t m, input logic oe);
        cmp("mode", {2'h0, m}, {2'h0, mode_r});
        cmp("line_oe", {3'h0, oe}, {3'h0, line_oe_r});
        cmp("aos_flag", {3'h0, m == e1tx_pkg::E1TX_ALL_ONES}, {3'h0, aos_r});
    endtask : chk_mode

    initial begin
        void'($urandom(74434));
        w(20);
        rst <= 1'b0;
        w(300);
        chk_mode(e1tx_pkg::E1TX_NORMAL, 1'b1);
        $display("stream test done");
        rdy_mode <= 2'h0;
        w(250);
        cmp("accept", 4'h0, {3'h0, acc_r});
        rdy_mode <= 2'h2;
        w(400);
        cmp("backlog", 4'h1, {3'h0, q.size() < 6});
        $display("fifo test done");
        @(negedge tclk) neg_hi <= 1'b1;
        repeat (16) @(negedge tclk);
        neg_hi <= 1'b0;
        w(40);
        cmp("single_rail", {3'h0, sr_m}, {3'h0, sr_r});
        @(negedge tclk) neg_hi <= 1'b1;
        repeat (20) @(negedge tclk);
        neg_hi <= 1'b0;
        w(40);
        cmp("single_rail", 4'h1, {3'h0, sr_r});
        w(300);
        $display("single rail test done");
        cmp_on <= 1'b0;
        rdy_mode <= 2'h1;
        hold_lvl <= 1'b1;
        run <= 1'b0;
        w(10);
        chk_mode(e1tx_pkg::E1TX_NORMAL, 1'b1);
        w(SL + 20);
        chk_mode(e1tx_pkg::E1TX_ALL_ONES, 1'b1);
        nrun = 0;
        w(300);
        cmp("aos_pulses", 4'h1, {3'h0, nrun >= 2 && nrun <= 3});
        run <= 1'b1;
        w(12);
        chk_mode(e1tx_pkg::E1TX_NORMAL, 1'b1);
        $display("all ones test done");
        hold_lvl <= 1'b0;
        run <= 1'b0;
        w(SL + 20);
        chk_mode(e1tx_pkg::E1TX_POWER_DOWN, 1'b0);
        run <= 1'b1;
        w(12);
        chk_mode(e1tx_pkg::E1TX_NORMAL, 1'b1);
        $display("power down test done");
        end_of_test();
    end
endmodule : test_e1tx_clock_mode_detect

`default_nettype wire
